// ---- rtl/common_ctrl_regs.svh ----
`ifndef COMMON_CTRL_REGS_SVH
`define COMMON_CTRL_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_RESET_CONTROL     18'h3_0b20
`define IDX_SPARE_AND_FORCE   18'h3_0b21
`define IDX_STATUS_RESERVED   18'h3_0b28
`define IDX_SOURCE_SUMMARY    18'h3_0b29
`define IDX_IRQ_STATUS        18'h3_0b30
`define IDX_IRQ_MASK          18'h3_0b31

// Field positions, common_reset_control
`define BIT_XCVR_HARD_RESET   4
`define BIT_MEMCTL_SOFT_RESET 5
`define BIT_LINK_A_SOFT_RESET 6
`define BIT_LINK_B_SOFT_RESET 7
`define CTRL_WRITE_MASK       8'h00_f0

// Field positions, common_spare_and_force
`define SPARE_MSB             6
`define BIT_FORCE             7

// Summary bit positions
`define SUM_TRANSCEIVER       0
`define SUM_MEMCTL_CORE       1
`define SUM_MEMCTL_FIFO       2
`define SUM_BUFFER_BANK       3
`define SUM_LINK_B_GROUP2     4
`define SUM_LINK_B_GROUP1     5
`define SUM_LINK_A_GROUP2     6
`define SUM_LINK_A_GROUP1     7

// Reset values
`define RST_BYTE              8'h00_00
`define RST_WORD              32'h0000_0000
`define ALL_ONES_BYTE         8'h00_ff

`endif

// ---- rtl/common_ctrl_pkg.sv ----
package common_ctrl_pkg;

    typedef logic [7:0] byte_reg_t;

    typedef enum logic [0:0] {
        APB_WAIT   = 1'b0,
        APB_ANSWER = 1'b1
    } apb_phase_t;

endpackage : common_ctrl_pkg

// ---- rtl/event_rise_detect.sv ----
`timescale 1ns/1ps
`include "common_ctrl_regs.svh"

module event_rise_detect #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk_in,
    input  wire logic             nrst_in,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] rise_out
);

    logic [WIDTH-1:0] prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // A persisting event gives one pulse only; it must drop before the next
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge mclk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    prev_q[i] <= 1'b0;
                end else begin
                    prev_q[i] <= level_in[i];
                end
            end
            assign rise_out[i] = level_in[i] & ~prev_q[i];
        end
    endgenerate

endmodule : event_rise_detect

// ---- rtl/sticky_flags.sv ----
`timescale 1ns/1ps
`include "common_ctrl_regs.svh"

module sticky_flags #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk_in,
    input  wire logic             nrst_in,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic [WIDTH-1:0] clr_in,
    output logic      [WIDTH-1:0] flags_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Set wins over clear so an event in the clearing cycle is kept
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge mclk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    flags_out[i] <= 1'b0;
                end else if (set_in[i]) begin
                    flags_out[i] <= 1'b1;
                end else if (clr_in[i]) begin
                    flags_out[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : sticky_flags

// ---- rtl/common_reset_and_interrupt_summary.sv ----
// Overview of operation
// - Writing one to the transceiver hard-reset bit holds the transceiver block in reset.
// - The hard-reset bit and the fabric reset input act alike; either resets the transceiver.
// - A control bit applies a software reset to the memory controller.
// - A control bit applies a software reset to packet link core A.
// - A control bit applies a software reset to packet link core B.
// - The seven spare bits are plain read/write storage, reset to zero, with no effect.
// - The force bit sets force_enabled_out and forces every event level high, setting each summary and status bit whose event was low.
// - The summary transceiver bit sets on an enabled transceiver interrupt.
// - A summary bit sets on an enabled memory controller interrupt not from its FIFOs.
// - A separate summary bit sets on an enabled memory controller FIFO interrupt.
// - A summary bit sets on an enabled interrupt from any buffer RAM FIFO bank.
// - A summary bit sets on an enabled interrupt from link B's second status group.
// - A summary bit sets on an enabled interrupt from link B's first status group.
// - A summary bit sets on an enabled interrupt from link A's second status group.
// - A summary bit sets on an enabled interrupt from link A's first status group.
// - Summary bits clear on read and set again only after the event drops and returns.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "common_ctrl_regs.svh"

module common_reset_and_interrupt_summary (
    input  wire logic                        mclk_in,
    input  wire logic                        nrst_in,
    // APB slave
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [19:0]                 paddr_in,
    input  wire logic [31:0]                 pwdata_in,
    input  wire logic [3:0]                  pstrb_in,
    output logic      [31:0]                 prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    // Enabled interrupt levels from the source blocks
    input  wire logic                        transceiver_event_in,
    input  wire logic                        memctl_core_event_in,
    input  wire logic                        memctl_fifo_event_in,
    input  wire logic                        buffer_bank_event_in,
    input  wire logic                        link_b_group2_event_in,
    input  wire logic                        link_b_group1_event_in,
    input  wire logic                        link_a_group2_event_in,
    input  wire logic                        link_a_group1_event_in,
    input  wire logic                        fabric_transceiver_reset_input_in,
    // Control outputs
    output logic                             transceiver_hard_reset_out,
    output logic                             memctl_soft_reset_out,
    output logic                             link_a_soft_reset_out,
    output logic                             link_b_soft_reset_out,
    output logic                             force_enabled_out,
    output logic                             irq_out,
    output common_ctrl_pkg::byte_reg_t       summary_out
);

    import common_ctrl_pkg::*;

    byte_reg_t   ctrl_q;
    byte_reg_t   spare_force_q;
    byte_reg_t   mask_q;
    byte_reg_t   summary_q;
    byte_reg_t   irq_status_q;
    byte_reg_t   event_level;
    byte_reg_t   event_rise;
    byte_reg_t   summary_clr;
    byte_reg_t   status_clr;
    apb_phase_t  phase_q;
    logic [17:0] reg_idx;
    logic        word_aligned;
    logic        access;
    logic        done;
    logic        wr_en;
    logic        rd_done;
    logic        hit_ctrl;
    logic        hit_spare;
    logic        hit_rsvd;
    logic        hit_summary;
    logic        hit_status;
    logic        hit_mask;
    logic        hit_any;
    byte_reg_t   rd_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    assign reg_idx      = paddr_in[19:2];
    assign word_aligned = (paddr_in[1:0] == 2'h0);
    assign hit_ctrl     = word_aligned && (reg_idx == `IDX_RESET_CONTROL);
    assign hit_spare    = word_aligned && (reg_idx == `IDX_SPARE_AND_FORCE);
    assign hit_rsvd     = word_aligned && (reg_idx == `IDX_STATUS_RESERVED);
    assign hit_summary  = word_aligned && (reg_idx == `IDX_SOURCE_SUMMARY);
    assign hit_status   = word_aligned && (reg_idx == `IDX_IRQ_STATUS);
    assign hit_mask     = word_aligned && (reg_idx == `IDX_IRQ_MASK);
    assign hit_any      = hit_ctrl | hit_spare | hit_rsvd | hit_summary
                        | hit_status | hit_mask;

    // One wait state so read data and pready come straight from flops
    assign access  = psel_in && penable_in;
    assign done    = access && (phase_q == APB_ANSWER);
    assign wr_en   = done && pwrite_in && hit_any && pstrb_in[0];
    assign rd_done = done && !pwrite_in;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            phase_q <= APB_WAIT;
        end else begin
            unique case (phase_q)
                APB_WAIT: begin
                    if (access) begin
                        phase_q <= APB_ANSWER;
                    end
                end
                APB_ANSWER: begin
                    phase_q <= APB_WAIT;
                end
            endcase
        end
    end

    always_comb begin
        rd_byte = `RST_BYTE;
        if (hit_ctrl) begin
            rd_byte = ctrl_q;
        end else if (hit_spare) begin
            rd_byte = spare_force_q;
        end else if (hit_summary) begin
            rd_byte = summary_q;
        end else if (hit_status) begin
            rd_byte = irq_status_q;
        end else if (hit_mask) begin
            rd_byte = mask_q;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= `RST_WORD;
            pslverr_out <= 1'b0;
        end else if (access && (phase_q == APB_WAIT)) begin
            pready_out  <= 1'b1;
            prdata_out  <= pwrite_in ? `RST_WORD : {24'h00_0000, rd_byte};
            pslverr_out <= !hit_any;
        end else begin
            pready_out  <= 1'b0;
            prdata_out  <= `RST_WORD;
            pslverr_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_q <= `RST_BYTE;
        end else if (wr_en && hit_ctrl) begin
            // Low nibble is reserved and stays zero
            ctrl_q <= pwdata_in[7:0] & `CTRL_WRITE_MASK;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            spare_force_q <= `RST_BYTE;
        end else if (wr_en && hit_spare) begin
            spare_force_q <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mask_q <= `RST_BYTE;
        end else if (wr_en && hit_mask) begin
            mask_q <= pwdata_in[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset outputs; registered so the targets see a clean level
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            transceiver_hard_reset_out <= 1'b0;
        end else begin
            transceiver_hard_reset_out <= ctrl_q[`BIT_XCVR_HARD_RESET]
                                        | fabric_transceiver_reset_input_in;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            memctl_soft_reset_out <= 1'b0;
            link_a_soft_reset_out <= 1'b0;
            link_b_soft_reset_out <= 1'b0;
        end else begin
            memctl_soft_reset_out <= ctrl_q[`BIT_MEMCTL_SOFT_RESET];
            link_a_soft_reset_out <= ctrl_q[`BIT_LINK_A_SOFT_RESET];
            link_b_soft_reset_out <= ctrl_q[`BIT_LINK_B_SOFT_RESET];
        end
    end

    // Source blocks force their own enabled bits; this one forces its inputs
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            force_enabled_out <= 1'b0;
        end else begin
            force_enabled_out <= spare_force_q[`BIT_FORCE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event gathering
    always_comb begin
        event_level                      = `RST_BYTE;
        event_level[`SUM_TRANSCEIVER]    = transceiver_event_in;
        event_level[`SUM_MEMCTL_CORE]    = memctl_core_event_in;
        event_level[`SUM_MEMCTL_FIFO]    = memctl_fifo_event_in;
        event_level[`SUM_BUFFER_BANK]    = buffer_bank_event_in;
        event_level[`SUM_LINK_B_GROUP2]  = link_b_group2_event_in;
        event_level[`SUM_LINK_B_GROUP1]  = link_b_group1_event_in;
        event_level[`SUM_LINK_A_GROUP2]  = link_a_group2_event_in;
        event_level[`SUM_LINK_A_GROUP1]  = link_a_group1_event_in;
        if (spare_force_q[`BIT_FORCE]) begin
            event_level = `ALL_ONES_BYTE;
        end
    end

    event_rise_detect #(
        .WIDTH (8)
    ) u_rise (
        .mclk_in  (mclk_in),
        .nrst_in  (nrst_in),
        .level_in (event_level),
        .rise_out (event_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Summary: cleared by reading it
    assign summary_clr = (rd_done && hit_summary) ? `ALL_ONES_BYTE : `RST_BYTE;

    sticky_flags #(
        .WIDTH (8)
    ) u_summary (
        .mclk_in   (mclk_in),
        .nrst_in   (nrst_in),
        .set_in    (event_rise),
        .clr_in    (summary_clr),
        .flags_out (summary_q)
    );

    // Interrupt status: same events, write one to clear
    assign status_clr = (wr_en && hit_status) ? pwdata_in[7:0] : `RST_BYTE;

    sticky_flags #(
        .WIDTH (8)
    ) u_status (
        .mclk_in   (mclk_in),
        .nrst_in   (nrst_in),
        .set_in    (event_rise),
        .clr_in    (status_clr),
        .flags_out (irq_status_q)
    );

    // Interrupt lags the status bit by one edge
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_status_q & mask_q);
        end
    end

    // Summary flags are already flops; exported for observation
    assign summary_out = summary_q;

endmodule : common_reset_and_interrupt_summary

// ---- bench/common_reset_and_interrupt_summary_chk.sv ----
`timescale 1ns/1ps
`include "common_ctrl_regs.svh"

module common_reset_and_interrupt_summary_chk (
    input wire logic              mclk_in,
    input wire logic              nrst_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic              pwrite_in,
    input wire logic [19:0]       paddr_in,
    input wire logic [31:0]       pwdata_in,
    input wire logic [3:0]        pstrb_in,
    input wire logic              pready_out,
    input wire logic              transceiver_event_in,
    input wire logic              memctl_core_event_in,
    input wire logic              memctl_fifo_event_in,
    input wire logic              buffer_bank_event_in,
    input wire logic              link_b_group2_event_in,
    input wire logic              link_b_group1_event_in,
    input wire logic              link_a_group2_event_in,
    input wire logic              link_a_group1_event_in,
    input wire logic              fabric_transceiver_reset_input_in,
    input wire logic              transceiver_hard_reset_out,
    input wire logic              memctl_soft_reset_out,
    input wire logic              link_a_soft_reset_out,
    input wire logic              link_b_soft_reset_out,
    input wire logic              force_enabled_out,
    input wire common_ctrl_pkg::byte_reg_t summary_out
);
    import common_ctrl_pkg::*;
    localparam logic [19:0] A_CTL = {`IDX_RESET_CONTROL, 2'b00};
    localparam logic [19:0] A_SPR = {`IDX_SPARE_AND_FORCE, 2'b00};
    localparam logic [19:0] A_SUM = {`IDX_SOURCE_SUMMARY, 2'b00};
    logic       xfer, wr_ctl, wr_spr, rd_sum;
    logic [7:0] ev, ev_q, rise;
    assign xfer   = psel_in && penable_in && pready_out;
    assign wr_ctl = xfer && pwrite_in && pstrb_in[0] && paddr_in == A_CTL;
    assign wr_spr = xfer && pwrite_in && pstrb_in[0] && paddr_in == A_SPR;
    assign rd_sum = xfer && !pwrite_in && paddr_in == A_SUM;
    assign ev = {link_a_group1_event_in, link_a_group2_event_in, link_b_group1_event_in,
                 link_b_group2_event_in, buffer_bank_event_in, memctl_fifo_event_in,
                 memctl_core_event_in, transceiver_event_in};
    assign rise = ev & ~ev_q;
    // Mirrors the rise detector, whose history is cleared by reset
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ev_q <= 8'h00;
        end else begin
            ev_q <= ev;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////////////////////////////////////////////
    a_fabric_xcvr_reset: assert property (fabric_transceiver_reset_input_in |=>
        transceiver_hard_reset_out) else $error("fabric reset not passed on");
    a_ctl_xcvr_reset: assert property (wr_ctl && pwdata_in[4] |-> ##2
        transceiver_hard_reset_out) else $error("hard reset bit not applied");
    a_soft_reset_bits: assert property (wr_ctl |-> ##2
        {link_b_soft_reset_out, link_a_soft_reset_out, memctl_soft_reset_out}
        == $past(pwdata_in[7:5], 2)) else $error("soft reset outputs wrong");
    a_soft_reset_hold: assert property (!wr_ctl && !$past(wr_ctl) |=>
        $stable({link_b_soft_reset_out, link_a_soft_reset_out, memctl_soft_reset_out}))
        else $error("soft reset changed without a write");
    a_force_bit: assert property (wr_spr |-> ##2
        force_enabled_out == $past(pwdata_in[7], 2)) else $error("force bit not applied");
    a_force_sets_all: assert property ($rose(force_enabled_out) |-> ##[0:3]
        summary_out == 8'hff) else $error("force did not set every summary bit");
    a_event_sets: assert property (rise != 8'h00 |=>
        (summary_out & $past(rise)) == $past(rise))
        else $error("event rise did not set summary");
    a_read_clears: assert property (rd_sum |=>
        (summary_out & ~$past(rise)) == 8'h00) else $error("summary not cleared by read");
    a_no_reset_set: assert property (!force_enabled_out |->
        (summary_out & ~$past(summary_out) & ~$past(rise)) == 8'h00)
        else $error("summary set without a new event");
    c_read_nonzero: cover property (rd_sum && summary_out != 8'h00);
    c_force_rise: cover property ($rose(force_enabled_out));
    c_hard_reset: cover property (wr_ctl && pwdata_in[4]);
endmodule : common_reset_and_interrupt_summary_chk

bind common_reset_and_interrupt_summary common_reset_and_interrupt_summary_chk chk_i (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .pready_out(pready_out), .transceiver_event_in(transceiver_event_in),
    .memctl_core_event_in(memctl_core_event_in), .memctl_fifo_event_in(memctl_fifo_event_in),
    .buffer_bank_event_in(buffer_bank_event_in),
    .link_b_group2_event_in(link_b_group2_event_in),
    .link_b_group1_event_in(link_b_group1_event_in),
    .link_a_group2_event_in(link_a_group2_event_in),
    .link_a_group1_event_in(link_a_group1_event_in),
    .fabric_transceiver_reset_input_in(fabric_transceiver_reset_input_in),
    .transceiver_hard_reset_out(transceiver_hard_reset_out),
    .memctl_soft_reset_out(memctl_soft_reset_out), .link_a_soft_reset_out(link_a_soft_reset_out),
    .link_b_soft_reset_out(link_b_soft_reset_out), .force_enabled_out(force_enabled_out),
    .summary_out(summary_out));

// ---- bench/common_reset_and_interrupt_summary_tb_top.sv ----
`timescale 1ns/1ps
`include "common_ctrl_regs.svh"

module common_reset_and_interrupt_summary_tb_top;
    import common_ctrl_pkg::*;
    localparam logic [19:0] A_CTL = {`IDX_RESET_CONTROL, 2'b00};
    localparam logic [19:0] A_SPR = {`IDX_SPARE_AND_FORCE, 2'b00};
    localparam logic [19:0] A_SUM = {`IDX_SOURCE_SUMMARY, 2'b00};
    localparam logic [19:0] A_STS = {`IDX_IRQ_STATUS, 2'b00};
    localparam logic [19:0] A_MSK = {`IDX_IRQ_MASK, 2'b00};
    localparam logic [19:0] REGS [6] = '{A_CTL, A_SPR, {`IDX_STATUS_RESERVED, 2'b00},
                                        A_SUM, A_STS, A_MSK};
    logic        mclk_in, nrst_in, psel, penable, pwrite, fabric, rerr;
    logic        pready, pslverr, xrst, mrst, arst, brst, frc, irq;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic [7:0]  ev;
    byte_reg_t   summary;
    int          error_cnt, n_checks;

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    common_reset_and_interrupt_summary uut (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .transceiver_event_in(ev[0]), .memctl_core_event_in(ev[1]),
        .memctl_fifo_event_in(ev[2]), .buffer_bank_event_in(ev[3]),
        .link_b_group2_event_in(ev[4]), .link_b_group1_event_in(ev[5]),
        .link_a_group2_event_in(ev[6]), .link_a_group1_event_in(ev[7]),
        .fabric_transceiver_reset_input_in(fabric), .transceiver_hard_reset_out(xrst),
        .memctl_soft_reset_out(mrst), .link_a_soft_reset_out(arst),
        .link_b_soft_reset_out(brst), .force_enabled_out(frc), .irq_out(irq),
        .summary_out(summary));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk

    // Request held until pready is seen at a rising edge; no latency assumed
    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk_in);
        penable <= 1'b1;
        do begin
            @(posedge mclk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        if (n >= 20) chk(1'b0, 1'b1, "no pready");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [19:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, exp, m);
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : wait_cyc

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst_in, psel, penable, pwrite, fabric, paddr, pwdata, ev} = '0;
        pstrb = 4'hf;
        wait_cyc(16);
        nrst_in <= 1'b1;
        foreach (REGS[i]) rd(REGS[i], 32'h0000_0000, "reset value");
        $display("test reset values done");
        for (int i = 4; i < 8; i++) begin
            apb(1'b1, A_CTL, 32'h0000_0001 << i);
            wait_cyc(2);
            chk({brst, arst, mrst, xrst}, 4'b0001 << (i - 4), "resets");
            rd(A_CTL, 32'h0000_0001 << i, "control readback");
        end
        apb(1'b1, A_SPR, 32'h0000_0055);
        @(posedge mclk_in);
        pstrb <= 4'h0;
        apb(1'b1, A_SPR, 32'h0000_007f);
        pstrb <= 4'hf;
        wait_cyc(20);
        chk({brst, arst, mrst, frc}, 4'b1000, "held reset");
        rd(A_SPR, 32'h0000_0055, "spare readback");
        apb(1'b1, A_CTL, 32'h0000_0000);
        wait_cyc(2);
        chk({brst, xrst}, 2'b00, "reset release");
        fabric <= 1'b1;
        wait_cyc(3);
        chk(xrst, 1'b1, "fabric reset");
        fabric <= 1'b0;
        wait_cyc(3);
        chk(xrst, 1'b0, "fabric release");
        $display("test reset controls done");
        // Event still high after the read must not set the bit again
        for (int i = 0; i < 8; i++) begin
            ev[i] <= 1'b1;
            wait_cyc(3);
            rd(A_SUM, 32'h0000_0001 << i, "event");
            rd(A_SUM, 32'h0000_0000, "persisting");
            ev[i] <= 1'b0;
            wait_cyc(2);
            ev[i] <= 1'b1;
            wait_cyc(3);
            rd(A_SUM, 32'h0000_0001 << i, "re-event");
            ev[i] <= 1'b0;
        end
        $display("test summary done");
        chk(irq, 1'b0, "masked irq");
        apb(1'b1, A_MSK, 32'h0000_0008);
        wait_cyc(2);
        chk(irq, 1'b1, "unmasked irq");
        apb(1'b1, A_STS, 32'h0000_0008);
        wait_cyc(2);
        chk(irq, 1'b0, "cleared irq");
        rd(A_STS, 32'h0000_00f7, "status after clear");
        apb(1'b1, A_STS, 32'h0000_00ff);
        rd(A_STS, 32'h0000_0000, "status empty");
        $display("test interrupt done");
        apb(1'b1, A_SPR, 32'h0000_0080);
        wait_cyc(4);
        chk(frc, 1'b1, "force out");
        rd(A_SUM, 32'h0000_00ff, "forced summary");
        rd(A_STS, 32'h0000_00ff, "forced status");
        chk(irq, 1'b1, "forced irq");
        apb(1'b1, A_SPR, 32'h0000_0000);
        apb(1'b1, A_STS, 32'h0000_00ff);
        apb(1'b0, 20'hc_2c90, 32'h0000_0000);
        chk({rerr, rdat}, 33'h1_0000_0000, "unmapped read");
        $display("test force and unmapped done");
        report_and_stop();
    end

    // Tests need a few hundred cycles; this bound of 30000 cycles is far beyond that
    initial begin
        #300us;
        chk(1'b0, 1'b1, "watchdog");
        report_and_stop();
    end
endmodule : common_reset_and_interrupt_summary_tb_top
